// ===== ehs_pkg.sv
// Shared constants and types for the host serial port
// Contract
// RQ1: Serial activity counts only while chip select is low.
// RQ2: 4-wire mode: select high means parameter byte, low means command byte.
// RQ3: Host sends nothing while busy output is low.
// RQ4: Busy output low during waveform output and temperature sensor traffic.
// RQ5: Hardware reset input is active low and resets all logic.
// RQ6: Strap low: 4-line slave, 8-bit units, separate select line.
// RQ7: Strap high: 3-line slave, 9-bit units, select input unused.
// RQ8: Only two modes; chosen by strap level, never by command.
// RQ9: Each bit is captured on serial clock rising edge under chip select.
// RQ10: Both writes from host and reads driving parameter bytes supported.
// RQ11: Device is I2C master to sensor: drives clock, drives or reads data.
// RQ12: Each transfer tagged by direction (0 write) and type (0 command).
// RQ13: Host sends MSB first, holds select stable for the whole byte.
// RQ14: 3-wire: first bit low command, high data; then MSB-first byte.
package ehs_pkg;
    localparam int unsigned EHS_BYTE_W    = 8;
    localparam int unsigned EHS_CNT_W     = 4;
    localparam logic [3:0]  EHS_UNIT4_END = 4'h7;  // Last bit index, 8-bit unit
    localparam logic [3:0]  EHS_UNIT3_END = 4'h8;  // Last bit index, 9-bit unit
    localparam logic [1:0]  EHS_STRAP_SETTLE = 2'h2;  // Edges to fill strap sync
    localparam logic        EHS_DIR_WRITE = 1'b0;
    localparam logic        EHS_DIR_READ  = 1'b1;
    localparam logic        EHS_BUSY_LOW  = 1'b0;
    localparam logic        EHS_OE_ON     = 1'b0;  // Enables are active low
    localparam logic        EHS_OE_OFF    = 1'b1;

    typedef enum logic [0:0] {
        EHS_KIND_CMD  = 1'b0,
        EHS_KIND_DATA = 1'b1
    } ehs_kind_t;

    typedef enum logic [0:0] {
        EHS_MODE_4W = 1'b0,
        EHS_MODE_3W = 1'b1
    } ehs_mode_t;

    // One received or sent unit with its attributes
    typedef struct packed {
        logic                  dir;
        ehs_kind_t             kind;
        logic [EHS_BYTE_W-1:0] value;
    } ehs_unit_t;
endpackage

// ===== ehs_sync.sv
// Two-stage level synchroniser
`timescale 1ns/1ps
module ehs_sync #(
    parameter logic RESET_VAL = 1'b0
) (
    input  wire logic clk,    // Destination clock
    input  wire logic rstn,   // Async reset, active low
    input  wire logic d,      // Level from another domain
    output logic      q       // Synchronised level
);
    logic meta;

    // First stage feeds only the second
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta <= RESET_VAL;
            q    <= RESET_VAL;
        end else begin
            meta <= d;
            q    <= meta;
        end
    end
endmodule

// ===== ehs_host_serial_port.sv
// Host serial port: SPI slave in link domain, word handoff to core clock
`timescale 1ns/1ps
module ehs_host_serial_port
    import ehs_pkg::*;
(
    input  wire logic   clk,                 // Core clock, 10 MHz
    input  wire logic   rstn,                // Hardware reset, active low
    input  wire logic   bus_mode_strap,      // Low 4-wire, high 3-wire
    input  wire logic   host_clk_pin,        // Serial clock from host
    input  wire logic   host_cs_n,           // Chip select, active low
    input  wire logic   host_dc_pin,         // Command/data select
    input  wire logic   host_dat_in,         // Serial data pin, input side
    output logic        host_dat_out,        // Serial data pin, output side
    output logic        host_dat_oe_n,       // Serial data enable, low drives
    output logic        busy_n,              // Busy pin, low when busy
    output logic        tempsense_i2c_clk,   // Sensor clock line
    input  wire logic   tempsense_i2c_dat_in, // Sensor data pin, input side
    output logic        tempsense_i2c_dat_out, // Sensor data, output side
    output logic        tempsense_i2c_dat_oe_n, // Sensor data enable, low on
    output ehs_unit_t   rx_unit,             // Last received unit
    output logic        rx_valid,            // One-cycle pulse per unit
    output logic        mode_3wire,          // Strap mode caught at reset
    input  wire logic [EHS_BYTE_W-1:0] tx_byte, // Next read parameter byte
    input  wire logic   tx_load,             // Pulse: stage tx_byte
    output logic        tx_pending,          // Staged byte not yet taken
    input  wire logic   waveform_active,     // Display waveform running
    input  wire logic   i2c_active,          // Sensor transaction running
    input  wire logic   i2c_clk_drive,       // Sensor clock level wanted
    input  wire logic   i2c_dat_drive_low,   // Pull sensor data low
    output logic        i2c_dat_seen         // Sensor data, synchronised
);
    // ---------------- Core clock domain ----------------
    logic       strap_s;
    logic       strap_taken;
    logic [1:0] strap_age;
    logic       rx_tog_s;
    logic       rx_tog_prev;
    logic       tx_tog;
    logic       tx_ack_s;
    logic [EHS_BYTE_W-1:0] tx_word;
    logic       i2c_dat_s;

    // ---------------- Link clock domain ----------------
    logic       link_rstn;
    logic       mode_link;
    logic [EHS_CNT_W-1:0] bit_cnt;
    logic [EHS_BYTE_W-1:0] rx_sh;
    logic       dc_bit;
    ehs_unit_t  rx_hold;
    logic       rx_tog;
    logic       tx_tog_link;
    logic       tx_ack;
    logic       rd_on;
    logic [EHS_BYTE_W-1:0] tx_sh;
    logic [EHS_CNT_W-1:0] unit_end;
    logic       unit_done;

    // Strap is quasi-static; synchronise before catching it
    ehs_sync u_strap (
        .clk  (clk),
        .rstn (rstn),
        .d    (bus_mode_strap),
        .q    (strap_s)
    );

    // RQ5: active-low reset clears state
    // RQ8: strap caught once
    // Sync holds its reset value first, so wait until it has filled
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            strap_taken <= 1'b0;
            strap_age   <= 2'h0;
            mode_3wire  <= EHS_MODE_4W;
        end else if (!strap_taken) begin
            if (strap_age == EHS_STRAP_SETTLE) begin
                strap_taken <= 1'b1;
                mode_3wire  <= strap_s;
            end else begin
                strap_age <= strap_age + 2'h1;
            end
        end
    end

    // Received-unit toggle into core domain
    ehs_sync u_rx_tog (
        .clk  (clk),
        .rstn (rstn),
        .d    (rx_tog),
        .q    (rx_tog_s)
    );

    // RQ12: unit published with attributes
    // Holding word is stable for several cycles around the toggle
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rx_tog_prev <= 1'b0;
            rx_valid    <= 1'b0;
            rx_unit     <= '0;
        end else begin
            rx_tog_prev <= rx_tog_s;
            rx_valid    <= rx_tog_s ^ rx_tog_prev;
            if (rx_tog_s ^ rx_tog_prev) begin
                rx_unit <= rx_hold;
            end
        end
    end

    // Read byte staging, acknowledged from link side
    ehs_sync u_tx_ack (
        .clk  (clk),
        .rstn (rstn),
        .d    (tx_ack),
        .q    (tx_ack_s)
    );

    // RQ10: read byte handoff
    // A load while one is pending is ignored; the staged byte is kept until taken
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_tog     <= 1'b0;
            tx_word    <= '0;
            tx_pending <= 1'b0;
        end else begin
            if (tx_load && (tx_tog == tx_ack_s)) begin
                tx_tog  <= ~tx_tog;
                tx_word <= tx_byte;
            end
            tx_pending <= (tx_tog != tx_ack_s) || tx_load;
        end
    end

    // RQ4: busy during waveform or sensor traffic
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            busy_n <= ~EHS_BUSY_LOW;
        end else begin
            busy_n <= (waveform_active || i2c_active) ? EHS_BUSY_LOW
                                                      : ~EHS_BUSY_LOW;
        end
    end

    // Sensor data line read back through two stages
    ehs_sync #(.RESET_VAL(1'b1)) u_i2c_dat (
        .clk  (clk),
        .rstn (rstn),
        .d    (tempsense_i2c_dat_in),
        .q    (i2c_dat_s)
    );

    // RQ11: master pins
    // Open drain data: only ever pulled low, released otherwise
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tempsense_i2c_clk      <= 1'b1;
            tempsense_i2c_dat_out  <= 1'b0;
            tempsense_i2c_dat_oe_n <= EHS_OE_OFF;
            i2c_dat_seen           <= 1'b1;
        end else begin
            tempsense_i2c_clk      <= i2c_clk_drive;
            tempsense_i2c_dat_out  <= 1'b0;
            tempsense_i2c_dat_oe_n <= i2c_dat_drive_low ? EHS_OE_ON
                                                        : EHS_OE_OFF;
            i2c_dat_seen           <= i2c_dat_s;
        end
    end

    // ================= Link side =================
    // RQ1: chip select high clears frame
    // Frame state ends with chip select itself, not with a clock edge
    assign link_rstn = rstn & ~host_cs_n;

    // Mode level into link domain
    ehs_sync u_mode (
        .clk  (host_clk_pin),
        .rstn (rstn),
        .d    (mode_3wire),
        .q    (mode_link)
    );

    ehs_sync u_tx_tog (
        .clk  (host_clk_pin),
        .rstn (rstn),
        .d    (tx_tog),
        .q    (tx_tog_link)
    );

    // RQ6: 8-bit units; RQ7: 9-bit units
    assign unit_end  = (mode_link == EHS_MODE_3W) ? EHS_UNIT3_END
                                                  : EHS_UNIT4_END;
    assign unit_done = (bit_cnt == unit_end);

    // RQ9: sample on rising edge
    // RQ13: MSB first shift
    always_ff @(posedge host_clk_pin or negedge link_rstn) begin
        if (!link_rstn) begin
            bit_cnt <= '0;
            rx_sh   <= '0;
            dc_bit  <= EHS_KIND_CMD;
        end else begin
            if (unit_done) begin
                bit_cnt <= '0;
            end else begin
                bit_cnt <= bit_cnt + 4'h1;
            end
            // RQ14: leading select bit
            if (mode_link == EHS_MODE_3W && bit_cnt == 4'h0) begin
                dc_bit <= host_dat_in;
            end else begin
                rx_sh <= {rx_sh[EHS_BYTE_W-2:0], host_dat_in};
            end
        end
    end

    // Completed unit held for the core side; survives frame end
    always_ff @(posedge host_clk_pin or negedge rstn) begin
        if (!rstn) begin
            rx_hold <= '0;
            rx_tog  <= 1'b0;
        end else if (unit_done && !host_cs_n) begin
            rx_hold.value <= {rx_sh[EHS_BYTE_W-2:0], host_dat_in};
            rx_hold.dir   <= rd_on ? EHS_DIR_READ : EHS_DIR_WRITE;
            // RQ2: select pin in 4-wire
            rx_hold.kind  <= (mode_link == EHS_MODE_3W)
                             ? ehs_kind_t'(dc_bit)
                             : ehs_kind_t'(host_dc_pin);
            rx_tog        <= ~rx_tog;
        end
    end

    // Read unit: staged byte taken at a unit boundary
    always_ff @(posedge host_clk_pin or negedge link_rstn) begin
        if (!link_rstn) begin
            rd_on <= 1'b0;
            tx_sh <= '0;
        end else if (unit_done) begin
            rd_on <= (tx_tog_link != tx_ack);
            tx_sh <= tx_word;
        end else if (rd_on &&
                     !(mode_link == EHS_MODE_3W && bit_cnt == 4'h0)) begin
            tx_sh <= {tx_sh[EHS_BYTE_W-2:0], 1'b0};
        end
    end

    // Acknowledge survives frames so the core never re-sends
    always_ff @(posedge host_clk_pin or negedge rstn) begin
        if (!rstn) begin
            tx_ack <= 1'b0;
        end else if (unit_done && !host_cs_n) begin
            tx_ack <= tx_tog_link;
        end
    end

    // RQ10: drive on falling edge
    // Host samples on the rise, so data changes half a period earlier
    always_ff @(negedge host_clk_pin or negedge link_rstn) begin
        if (!link_rstn) begin
            host_dat_out  <= 1'b0;
            host_dat_oe_n <= EHS_OE_OFF;
        end else begin
            host_dat_out  <= tx_sh[EHS_BYTE_W-1];
            host_dat_oe_n <= (rd_on &&
                              !(mode_link == EHS_MODE_3W &&
                                bit_cnt == 4'h0)) ? EHS_OE_ON : EHS_OE_OFF;
        end
    end
endmodule

// ===== ehs_host_model.sv
// Host-side serial master model for the bench
`timescale 1ns/1ps
module ehs_host_model
    import ehs_pkg::*;
(
    output logic      host_clk_pin,  // Serial clock
    output logic      host_cs_n,     // Chip select
    output logic      host_dc_pin,   // Command/data select
    output logic      host_dat_in,   // Resolved data wire
    input  wire logic host_dat_out,  // Device data
    input  wire logic host_dat_oe_n  // Device enable
);
    logic sda = 1'b1;
    // Device owns the wire while its enable is low
    assign host_dat_in = (host_dat_oe_n == EHS_OE_ON) ? host_dat_out : sda;
    // Clock rests low between frames
    initial {host_clk_pin, host_cs_n, host_dc_pin} = 3'b010;
    task automatic frame(input logic on);
        #60 host_cs_n = !on;
        #70;
    endtask
    // MSB first, select held for the unit
    task automatic xfer(input int n, input logic [8:0] bits, input logic dc,
                        input logic rd, output logic [8:0] seen);
        seen = 9'h000;
        host_dc_pin = dc;
        for (int i = n - 1; i >= 0; i--) begin
            // Released line toggles so a stale level never passes
            sda = (rd && i < 8) ? !sda : bits[i];
            #7.5 host_clk_pin = 1'b1;
            seen = {seen[7:0], host_dat_in};
            #7.5 host_clk_pin = 1'b0;
        end
    endtask
endmodule

// ===== ehs_port_assertions.sv
// Port checker for the host serial port
`timescale 1ns/1ps
module ehs_port_checker
    import ehs_pkg::*;
(
    input wire logic      clk,                    // Core clock
    input wire logic      rstn,                   // Reset
    input wire logic      busy_n,                 // Busy pin
    input wire logic      waveform_active,        // Waveform
    input wire logic      i2c_active,             // Sensor traffic
    input wire logic      tempsense_i2c_clk,      // Sensor clock
    input wire logic      i2c_clk_drive,          // Wanted clock
    input wire logic      tempsense_i2c_dat_oe_n, // Sensor enable
    input wire logic      i2c_dat_drive_low,      // Pull low
    input wire ehs_unit_t rx_unit,                // Unit
    input wire logic      rx_valid,               // Unit pulse
    input wire logic      tx_load,                // Stage pulse
    input wire logic      tx_pending              // Staged
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Busy tracks its causes one clock late
    a_busy_set: assert property (
        (waveform_active || i2c_active) |=> !busy_n) else $error("no busy");
    a_busy_clear: assert property (
        !(waveform_active || i2c_active) |=> busy_n) else $error("busy stuck");
    // Units are spaced, so reports are too
    a_rx_spacing: assert property (
        rx_valid |=> !rx_valid [*3]) else $error("pulse too long");
    a_rx_hold: assert property (
        !rx_valid |-> $stable(rx_unit)) else $error("unit changed");
    a_tx_stage: assert property (
        tx_load && !tx_pending |=> tx_pending) else $error("not staged");
    a_tx_cause: assert property (
        $rose(tx_pending) |-> $past(tx_load)) else $error("stray stage");
    a_scl_follow: assert property (
        $past(rstn) |-> tempsense_i2c_clk == $past(i2c_clk_drive))
        else $error("sensor clock lag");
    a_sda_pull: assert property (
        $past(rstn) |-> tempsense_i2c_dat_oe_n == !$past(i2c_dat_drive_low))
        else $error("sensor data lag");
    c_data: cover property (rx_valid && rx_unit.kind == EHS_KIND_DATA);
    c_read: cover property (rx_valid && rx_unit.dir == EHS_DIR_READ);
    c_busy: cover property (!busy_n);
endmodule
bind ehs_host_serial_port ehs_port_checker i_chk (.clk, .rstn, .busy_n,
    .waveform_active, .i2c_active, .tempsense_i2c_clk, .i2c_clk_drive,
    .tempsense_i2c_dat_oe_n, .i2c_dat_drive_low, .rx_unit, .rx_valid,
    .tx_load, .tx_pending);

// ===== ehs_host_serial_port_bench.sv
// Self-checking bench for the host serial port
`timescale 1ns/1ps
module ehs_host_serial_port_bench;
    import ehs_pkg::*;
    logic       clk, host_clk_pin, host_cs_n, host_dc_pin, host_dat_in;
    logic       host_dat_out, host_dat_oe_n, busy_n, tempsense_i2c_clk;
    logic       tempsense_i2c_dat_out, tempsense_i2c_dat_oe_n, rx_valid;
    logic       mode_3wire, tx_pending, i2c_dat_seen, sens_dat, seen;
    logic       rstn = 1'b0, bus_mode_strap = 1'b0, tx_load = 1'b0;
    logic       waveform_active = 1'b0, i2c_active = 1'b0;
    logic       i2c_clk_drive = 1'b1, i2c_dat_drive_low = 1'b0;
    logic [7:0] tx_byte = 8'h00;
    logic [8:0] s;
    ehs_unit_t  rx_unit;
    int         num_errors = 0;
    int         num_checks = 0;
    // Sensor data wire has a pull-up
    assign sens_dat = tempsense_i2c_dat_oe_n ? 1'b1 : tempsense_i2c_dat_out;
    initial begin
        clk = 1'b0;
        forever #50 clk = !clk;
    end
    // Device and host model share the serial wires
    ehs_host_serial_port i_dut (.clk, .rstn, .bus_mode_strap, .host_clk_pin,
        .host_cs_n, .host_dc_pin, .host_dat_in, .host_dat_out, .host_dat_oe_n,
        .busy_n, .tempsense_i2c_clk, .tempsense_i2c_dat_in(sens_dat),
        .tempsense_i2c_dat_out, .tempsense_i2c_dat_oe_n, .rx_unit, .rx_valid,
        .mode_3wire, .tx_byte, .tx_load, .tx_pending, .waveform_active,
        .i2c_active, .i2c_clk_drive, .i2c_dat_drive_low, .i2c_dat_seen);
    ehs_host_model i_host (.host_clk_pin, .host_cs_n, .host_dc_pin,
        .host_dat_in, .host_dat_out, .host_dat_oe_n);
    task automatic chk(string what, logic [9:0] exp, logic [9:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // One unit out, its report awaited for at most 20 clocks
    task automatic unit(logic k, logic [7:0] b, logic rd, logic [7:0] exp);
        // Select inverted in 3-wire mode, where it must be ignored
        i_host.xfer(bus_mode_strap ? 9 : 8, {k, b}, k ^ bus_mode_strap, rd, s);
        for (int n = 0; n < 20 && rx_valid !== 1'b1; n++) @(negedge clk);
        chk("rx_valid", 10'h001, {9'h000, rx_valid});
        if (rx_valid !== 1'b1) give_verdict();
        chk("rx_unit", {rd, k, exp}, rx_unit);
        if (rd) chk("read byte", {2'b11, exp}, {2'b11, s[7:0]});
        @(negedge clk);
        chk("rx_valid drop", 10'h000, {9'h000, rx_valid});
        @(negedge clk);
    endtask
    task automatic do_reset(logic m);
        @(posedge clk);
        rstn <= 1'b0;
        bus_mode_strap <= m;
        repeat (20) @(posedge clk);
        chk("busy_n in reset", 10'h001, {9'h000, busy_n});
        rstn <= 1'b1;
        repeat (5) @(posedge clk);
        i_host.xfer(2, 9'h003, 1'b0, 1'b0, s);
        @(negedge clk);
        chk("mode_3wire", {9'h000, m}, {9'h000, mode_3wire});
    endtask
    // Causes end at zero so no unit goes out while busy
    // host silent while busy
    task automatic t_busy();
        for (int k = 3; k >= 0; k--) begin
            @(posedge clk);
            {i2c_active, waveform_active} <= k[1:0];
            {i2c_dat_drive_low, i2c_clk_drive} <= k[1:0];
            repeat (5) @(posedge clk);
            @(negedge clk);
            chk("busy_n", {9'h000, k[1:0] == 2'b00}, {9'h000, busy_n});
            chk("sensor", {8'h00, !k[1], k[0]},
                {8'h00, i2c_dat_seen, tempsense_i2c_clk});
        end
    endtask
    // Partial unit ended by chip select leaves no report
    task automatic t_abort();
        seen = 1'b0;
        i_host.frame(1'b1);
        i_host.xfer(4, 9'h0ff, 1'b1, 1'b0, s);
        i_host.frame(1'b0);
        repeat (8) begin
            @(negedge clk);
            seen = seen | rx_valid;
        end
        chk("partial unit", 10'h000, {9'h000, seen});
    endtask
    // Parameter, command, then a staged read in one frame
    task automatic t_traffic();
        i_host.frame(1'b1);
        unit(EHS_KIND_DATA, 8'h3c, 1'b0, 8'h3c);
        @(posedge clk);
        tx_byte <= 8'h96;
        tx_load <= 1'b1;
        @(posedge clk);
        tx_load <= 1'b0;
        @(negedge clk);
        chk("tx_pending", 10'h001, {9'h000, tx_pending});
        unit(EHS_KIND_CMD, 8'h71, 1'b0, 8'h71);
        unit(EHS_KIND_DATA, 8'h00, 1'b1, 8'h96);
        i_host.frame(1'b0);
        chk("oe released", 10'h001, {9'h000, host_dat_oe_n});
    endtask
    // Main sequence: 4-wire, then 3-wire after a second reset
    initial begin
        do_reset(1'b0);
        t_busy();
        t_abort();
        t_traffic();
        do_reset(1'b1);
        t_traffic();
        give_verdict();
    end
endmodule
